/* File: hw/baud_pkg.sv */
package baud_pkg;

    // ************************************************
    // Register indices, byte address is index times 4
    // ************************************************
    localparam logic [7:0] RXC_INDEX    = 8'h18;
    localparam logic [7:0] TXC_INDEX    = 8'h98;
    localparam logic [7:0] DIV_INDEX    = 8'h99;
    localparam logic [7:0] STATUS_INDEX = 8'h0C;
    localparam logic [7:0] RXBUF_INDEX  = 8'h1A;

    localparam int         ADDR_WIDTH   = 10;
    localparam logic [9:0] RXC_ADDR     = {RXC_INDEX, 2'h0};
    localparam logic [9:0] TXC_ADDR     = {TXC_INDEX, 2'h0};
    localparam logic [9:0] DIV_ADDR     = {DIV_INDEX, 2'h0};
    localparam logic [9:0] STATUS_ADDR  = {STATUS_INDEX, 2'h0};
    localparam logic [9:0] RXBUF_ADDR   = {RXBUF_INDEX, 2'h0};

    // ************************************************
    // Field positions
    // ************************************************
    localparam int TX_CLOCK_SOURCE = 7;
    localparam int TX_ENABLE       = 5;
    localparam int TX_SYNC         = 4;
    localparam int TX_HIGH_SPEED   = 2;
    localparam int TX_SHIFT_EMPTY  = 1;
    localparam int RX_SINGLE       = 5;
    localparam int RX_CONTINUOUS   = 4;
    localparam int RX_ADDR_DETECT  = 3;
    localparam int RX_FRAMING      = 2;
    localparam int RX_OVERRUN      = 1;
    localparam int RX_NINTH        = 0;
    localparam int WORD_NINTH      = 8;

    // ************************************************
    // Reset values and write masks
    // ************************************************
    localparam logic [7:0] TXC_RESET      = 8'h02;
    localparam logic [7:0] RXC_RESET      = 8'h00;
    localparam logic [7:0] DIV_RESET      = 8'h00;
    localparam logic [7:0] TXC_WRITE_MASK = 8'hF5;
    localparam logic [7:0] RXC_WRITE_MASK = 8'hF8;

    // ************************************************
    // Divide ratios minus one, and bus answers
    // ************************************************
    localparam int         PRESCALE_WIDTH = 6;
    localparam logic [5:0] RATIO_ASYNC    = 6'h3F;
    localparam logic [5:0] RATIO_FAST     = 6'h0F;
    localparam logic [5:0] RATIO_SYNC     = 6'h03;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

endpackage

/* File: hw/rate_generator.sv */
`timescale 1ns/1ps
module rate_generator #(
    parameter int DIVISOR_WIDTH  = 8,
    parameter int PRESCALE_WIDTH = 6
) (
    input  wire logic     aclk,    // System clock
    input  wire logic     aresetn, // Synchronous reset
    input  wire logic     ce,      // Clock enable
    rate_generator_if.timer gen    // Control and ticks
);

    if (DIVISOR_WIDTH != 8 || PRESCALE_WIDTH < baud_pkg::PRESCALE_WIDTH) begin : g_check
        $error("rate_generator: unsupported widths");
    end

    typedef struct packed {
        logic [PRESCALE_WIDTH-1:0] pre;
        logic [DIVISOR_WIDTH-1:0]  cnt;
        logic                      tick;
        logic                      sample;
    } gen_state_type;

    gen_state_type state;
    gen_state_type next_state;
    logic          last_div;
    logic [PRESCALE_WIDTH-1:0] ratio_last;

    assign ratio_last = PRESCALE_WIDTH'(gen.ratio_last);
    assign last_div   = (state.cnt == gen.divisor);

    // ************************************************
    // Prescaler then divisor counter
    // ************************************************
    always_comb begin
        next_state        = state;
        next_state.tick   = 1'b0;
        next_state.sample = 1'b0;
        if (gen.clear) begin
            next_state.pre = '0; // see (RULE8) see (RULE13)
            next_state.cnt = '0;
        end else begin
            if (last_div && state.pre >= ratio_last - PRESCALE_WIDTH'(3) && state.pre != ratio_last) begin
                next_state.sample = 1'b1; // see (RULE9)
            end
            if (state.pre == ratio_last) begin
                next_state.pre = '0;
                if (last_div) begin
                    next_state.cnt  = '0; // see (RULE1) see (RULE7)
                    next_state.tick = 1'b1; // see (RULE15)
                end else begin
                    next_state.cnt = state.cnt + DIVISOR_WIDTH'(1);
                end
            end else begin
                next_state.pre = state.pre + PRESCALE_WIDTH'(1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign gen.tick   = state.tick;
    assign gen.sample = state.sample;

endmodule

/* File: hw/rate_generator_if.sv */
`timescale 1ns/1ps
interface rate_generator_if;
    logic [7:0] divisor;
    logic [5:0] ratio_last;
    logic       clear;
    logic       tick;
    logic       sample;

    modport control (output divisor, output ratio_last, output clear, input tick, input sample);
    modport timer   (input divisor, input ratio_last, input clear, output tick, output sample);
endinterface

/* File: hw/usart_baud_rate_generator.sv */
// Contract
// (RULE1) One free-running 8-bit timer, shared by both modes, has its period set by the divisor.
// (RULE2) High-speed select picks the ratio in asynchronous mode and is ignored in synchronous mode.
// (RULE3) Asynchronous normal speed gives a rate of clock over 64 times divisor plus one.
// (RULE4) Asynchronous high speed gives a rate of clock over 16 times divisor plus one.
// (RULE5) Synchronous mode gives a rate of clock over 4 times divisor plus one, with no fast variant.
// (RULE6) The divisor sets the rate only as clock master; a synchronous slave leaves the timer idle.
// (RULE7) The divisor is unsigned 8-bit over its full range, zero fastest and maximum slowest.
// (RULE8) Any divisor write clears the timer at once so the new rate starts without delay.
// (RULE9) The receive line is sampled three times per bit and a majority vote decides the level.
// (RULE10) Transmit control holds the documented bit layout, bit 3 reads zero, reset is 0000 -010.
// (RULE11) The divisor resets to all zeros.
// (RULE12) With address detect on, only words with ninth bit one are buffered and raise the flag.
// (RULE13) The timer is held in reset while transmit, continuous and single receive enables are clear.
// (RULE14) With address detect off, every received word is buffered whatever its ninth bit.
// (RULE15) The timer counts divisor plus one periods, emits one-cycle ticks and reloads.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module usart_baud_rate_generator (
    input  wire logic        aclk,               // System clock, 200 MHz
    input  wire logic        aresetn,            // Synchronous reset, active low
    input  wire logic        ce,                 // Clock enable
    input  wire logic [9:0]  s_axi_awaddr,       // Write address
    input  wire logic        s_axi_awvalid,      // Write address valid
    output logic             s_axi_awready,      // Write address ready
    input  wire logic [31:0] s_axi_wdata,        // Write data
    input  wire logic [3:0]  s_axi_wstrb,        // Write strobes
    input  wire logic        s_axi_wvalid,       // Write data valid
    output logic             s_axi_wready,       // Write data ready
    output logic [1:0]       s_axi_bresp,        // Write response
    output logic             s_axi_bvalid,       // Write response valid
    input  wire logic        s_axi_bready,       // Write response ready
    input  wire logic [9:0]  s_axi_araddr,       // Read address
    input  wire logic        s_axi_arvalid,      // Read address valid
    output logic             s_axi_arready,      // Read address ready
    output logic [31:0]      s_axi_rdata,        // Read data
    output logic [1:0]       s_axi_rresp,        // Read response
    output logic             s_axi_rvalid,       // Read data valid
    input  wire logic        s_axi_rready,       // Read data ready
    input  wire logic        serial_receive_pin, // Receive line, asynchronous
    input  wire logic        shift_register_empty, // Transmit shift register empty
    input  wire logic        framing_error,      // From receiver
    input  wire logic        overrun_error,      // From receiver
    input  wire logic        rx_word_valid,      // Received word strobe
    input  wire logic [8:0]  rx_word,            // Received word, 9 bits
    output logic             rate_tick,          // One-cycle bit-rate tick
    output logic             rx_level,           // Majority receive level
    output logic             receive_flag,       // Receive buffer full
    output logic [7:0]       transmit_control,   // Transmit control byte
    output logic [7:0]       receive_control     // Receive control byte
);

    typedef struct packed {
        logic [1:0]  rx_sync;
        logic [2:0]  samples;
        logic        rx_level;
        logic [7:0]  tx_control;
        logic [7:0]  rx_control;
        logic [7:0]  divisor;
        logic [7:0]  rx_buffer;
        logic        rx_ninth;
        logic        receive_flag;
        logic        gen_clear;
        logic        awready;
        logic        wready;
        logic        aw_held;
        logic        w_held;
        logic [9:0]  waddr;
        logic [7:0]  wdata;
        logic        wlane;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } top_state_type;

    localparam top_state_type RESET_STATE = '{
        rx_sync:      2'h3,
        samples:      3'h7,
        rx_level:     1'b1,
        tx_control:   baud_pkg::TXC_RESET,
        rx_control:   baud_pkg::RXC_RESET,
        divisor:      baud_pkg::DIV_RESET,
        rx_buffer:    8'h00,
        rx_ninth:     1'b0,
        receive_flag: 1'b0,
        gen_clear:    1'b1,
        awready:      1'b1,
        wready:       1'b1,
        aw_held:      1'b0,
        w_held:       1'b0,
        waddr:        10'h000,
        wdata:        8'h00,
        wlane:        1'b0,
        bvalid:       1'b0,
        bresp:        2'h0,
        arready:      1'b1,
        rvalid:       1'b0,
        rdata:        32'h0000_0000,
        rresp:        2'h0
    };

    top_state_type    state;
    top_state_type    next_state;
    rate_generator_if gen ();

    logic       run;
    logic       master;
    logic       sync_mode;
    logic       write_now;
    logic       read_now;
    logic       div_write;
    logic       word_accept;
    logic [7:0] tx_read;
    logic [7:0] rx_read;

    // ************************************************
    // Mode decode
    // ************************************************
    assign sync_mode = state.tx_control[baud_pkg::TX_SYNC];
    assign master    = !sync_mode || state.tx_control[baud_pkg::TX_CLOCK_SOURCE]; // see (RULE6)
    assign run       = master && (state.tx_control[baud_pkg::TX_ENABLE]
                       || state.rx_control[baud_pkg::RX_CONTINUOUS]
                       || state.rx_control[baud_pkg::RX_SINGLE]); // see (RULE13)

    always_comb begin
        if (sync_mode) begin
            gen.ratio_last = baud_pkg::RATIO_SYNC; // see (RULE5) see (RULE2)
        end else if (state.tx_control[baud_pkg::TX_HIGH_SPEED]) begin
            gen.ratio_last = baud_pkg::RATIO_FAST; // see (RULE4)
        end else begin
            gen.ratio_last = baud_pkg::RATIO_ASYNC; // see (RULE3)
        end
    end

    assign gen.divisor = state.divisor;
    assign gen.clear   = state.gen_clear;

    rate_generator #(
        .DIVISOR_WIDTH  (8),
        .PRESCALE_WIDTH (baud_pkg::PRESCALE_WIDTH)
    ) u_rate_generator (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .gen     (gen.timer)
    );

    // ************************************************
    // Read values
    // ************************************************
    always_comb begin
        tx_read = state.tx_control;
        tx_read[3] = 1'b0; // see (RULE10)
        tx_read[baud_pkg::TX_SHIFT_EMPTY] = shift_register_empty;
        rx_read = state.rx_control;
        rx_read[baud_pkg::RX_FRAMING] = framing_error;
        rx_read[baud_pkg::RX_OVERRUN] = overrun_error;
        rx_read[baud_pkg::RX_NINTH]   = state.rx_ninth;
    end

    assign write_now   = state.aw_held && state.w_held && !state.bvalid;
    assign read_now    = s_axi_arvalid && state.arready;
    assign div_write   = write_now && state.wlane && state.waddr == baud_pkg::DIV_ADDR;
    assign word_accept = rx_word_valid
                         && (!state.rx_control[baud_pkg::RX_ADDR_DETECT] // see (RULE14)
                         || rx_word[baud_pkg::WORD_NINTH]); // see (RULE12)

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        next_state = state;

        // Receive line synchroniser and majority vote
        next_state.rx_sync = {state.rx_sync[0], serial_receive_pin};
        if (gen.sample) begin
            next_state.samples = {state.samples[1:0], state.rx_sync[1]}; // see (RULE9)
        end
        if (gen.tick) begin
            next_state.rx_level = (state.samples[0] & state.samples[1])
                                | (state.samples[0] & state.samples[2])
                                | (state.samples[1] & state.samples[2]); // see (RULE9)
        end

        // Generator clear on divisor write, mode write or idle
        next_state.gen_clear = !run || div_write // see (RULE8) see (RULE13)
                               || (write_now && state.waddr == baud_pkg::TXC_ADDR);

        // Write address and data, either order
        if (s_axi_awvalid && state.awready) begin
            next_state.awready = 1'b0;
            next_state.aw_held = 1'b1;
            next_state.waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && state.wready) begin
            next_state.wready  = 1'b0;
            next_state.w_held  = 1'b1;
            next_state.wdata   = s_axi_wdata[7:0];
            next_state.wlane   = s_axi_wstrb[0];
        end

        if (write_now) begin
            next_state.bvalid  = 1'b1;
            next_state.bresp   = baud_pkg::RESP_OKAY;
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            case (state.waddr)
                baud_pkg::TXC_ADDR: begin
                    if (state.wlane) begin
                        next_state.tx_control = (state.wdata & baud_pkg::TXC_WRITE_MASK)
                            | (state.tx_control & ~baud_pkg::TXC_WRITE_MASK); // see (RULE10)
                    end
                end
                baud_pkg::RXC_ADDR: begin
                    if (state.wlane) begin
                        next_state.rx_control = (state.wdata & baud_pkg::RXC_WRITE_MASK)
                            | (state.rx_control & ~baud_pkg::RXC_WRITE_MASK);
                    end
                end
                baud_pkg::DIV_ADDR: begin
                    if (state.wlane) begin
                        next_state.divisor = state.wdata; // see (RULE7)
                    end
                end
                baud_pkg::STATUS_ADDR, baud_pkg::RXBUF_ADDR: begin
                    next_state.bresp = baud_pkg::RESP_OKAY;
                end
                default: begin
                    next_state.bresp = baud_pkg::RESP_SLVERR;
                end
            endcase
        end

        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid  = 1'b0;
            next_state.awready = 1'b1;
            next_state.wready  = 1'b1;
        end

        // Read channel, buffer read clears the flag
        if (read_now) begin
            next_state.arready = 1'b0;
            next_state.rvalid  = 1'b1;
            next_state.rresp   = baud_pkg::RESP_OKAY;
            next_state.rdata   = 32'h0000_0000;
            case (s_axi_araddr)
                baud_pkg::TXC_ADDR:    next_state.rdata[7:0] = tx_read;
                baud_pkg::RXC_ADDR:    next_state.rdata[7:0] = rx_read;
                baud_pkg::DIV_ADDR:    next_state.rdata[7:0] = state.divisor;
                baud_pkg::STATUS_ADDR: next_state.rdata[0]   = state.receive_flag;
                baud_pkg::RXBUF_ADDR: begin
                    next_state.rdata[7:0]   = state.rx_buffer;
                    next_state.receive_flag = 1'b0;
                end
                default: begin
                    next_state.rresp = baud_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid  = 1'b0;
            next_state.arready = 1'b1;
        end

        // Address filter, a new word wins over a clearing read
        if (word_accept) begin
            next_state.rx_buffer    = rx_word[7:0]; // see (RULE12) see (RULE14)
            next_state.rx_ninth     = rx_word[baud_pkg::WORD_NINTH];
            next_state.receive_flag = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= RESET_STATE; // see (RULE11) see (RULE10)
        end else if (ce) begin
            state <= next_state;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign s_axi_awready    = state.awready;
    assign s_axi_wready     = state.wready;
    assign s_axi_bvalid     = state.bvalid;
    assign s_axi_bresp      = state.bresp;
    assign s_axi_arready    = state.arready;
    assign s_axi_rvalid     = state.rvalid;
    assign s_axi_rdata      = state.rdata;
    assign s_axi_rresp      = state.rresp;
    assign rate_tick        = gen.tick;
    assign rx_level         = state.rx_level;
    assign receive_flag     = state.receive_flag;
    assign transmit_control = state.tx_control;
    assign receive_control  = state.rx_control;

endmodule

/* File: verif/baud_checker_asserts.sv */
`timescale 1ns/1ps
module baud_checker (
    input wire logic       aclk,             // System clock
    input wire logic       aresetn,          // Synchronous reset, active low
    input wire logic       s_axi_awvalid,    // Write address valid
    input wire logic       s_axi_awready,    // Write address ready
    input wire logic       s_axi_wvalid,     // Write data valid
    input wire logic       s_axi_wready,     // Write data ready
    input wire logic [1:0] s_axi_bresp,      // Write response
    input wire logic       s_axi_bvalid,     // Write response valid
    input wire logic       rate_tick,        // Bit-rate tick
    input wire logic       rx_level,         // Majority receive level
    input wire logic       receive_flag,     // Buffer full
    input wire logic       rx_word_valid,    // Received word strobe
    input wire logic [8:0] rx_word,          // Received word
    input wire logic [7:0] transmit_control, // Transmit control byte
    input wire logic [7:0] receive_control   // Receive control byte
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_tick_spacing: assert property (rate_tick |=> (!rate_tick) [*3])
        else $error("ticks too close");
    a_idle_quiet: assert property (!(transmit_control[5] || receive_control[5] || receive_control[4]) [*4]
        |-> !rate_tick) else $error("tick while idle");
    a_slave_quiet: assert property ((transmit_control[4] && !transmit_control[7]) [*4] |-> !rate_tick)
        else $error("tick as slave");
    a_filter_drop: assert property (rx_word_valid && receive_control[3] && !rx_word[8] && !receive_flag
        |=> !receive_flag) else $error("data word loaded");
    a_flag_load: assert property (rx_word_valid && (!receive_control[3] || rx_word[8]) |=> receive_flag)
        else $error("flag not raised");
    a_level_at_tick: assert property ($changed(rx_level) |-> $past(rate_tick))
        else $error("level moved off tick");
    a_reset_values: assert property ($rose(aresetn) |-> transmit_control == baud_pkg::TXC_RESET
        && receive_control == baud_pkg::RXC_RESET && !receive_flag) else $error("bad reset value");
    a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("bresp late");

    c_tick: cover property (rate_tick);
    c_flag: cover property ($rose(receive_flag));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == baud_pkg::RESP_SLVERR);
endmodule

bind usart_baud_rate_generator baud_checker chk_u (.*);

/* File: verif/remote_transceiver.sv */
`timescale 1ns/1ps
module remote_transceiver (
    input  wire logic aclk,   // System clock
    input  wire logic level,  // Level to send
    input  wire logic glitch, // Invert one cycle in three
    output logic      line    // Receive line of the device
);
    logic [1:0] phase = 2'h0;

    initial line = 1'b1;
    // One short spike per three cycles never wins a three-sample vote
    always @(posedge aclk) begin
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        line  <= level ^ (glitch && phase == 2'h0);
    end
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
    logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, line_level = 1'b1, line_glitch = 1'b0;
    logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1, shift_register_empty = 1'b1;
    logic        framing_error = 1'b0, overrun_error = 1'b0, rx_word_valid = 1'b0;
    logic [8:0]  rx_word = 9'h000;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        serial_receive_pin, rate_tick, rx_level, receive_flag;
    logic [7:0]  transmit_control, receive_control;
    int          mismatches = 0, checks = 0;

    always #2.5 aclk = ~aclk;

    usart_baud_rate_generator dut_u (
        .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .serial_receive_pin, .shift_register_empty, .framing_error, .overrun_error, .rx_word_valid,
        .rx_word, .rate_tick, .rx_level, .receive_flag, .transmit_control, .receive_control
    );
    remote_transceiver link_u (.aclk, .level(line_level), .glitch(line_glitch), .line(serial_receive_pin));

    task automatic complete_run;
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stall(input string what);
        mismatches++;
        $display("[FAIL] %s expected answer seen none", what);
        complete_run();
    endtask

    task automatic reg_write(input logic [9:0] a, input logic [7:0] d, input logic [1:0] resp = baud_pkg::RESP_OKAY);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (n == 64) stall("write");
        check("bresp", {30'h0, resp}, {30'h0, s_axi_bresp});
    endtask

    task automatic reg_read(input logic [9:0] a, input logic [7:0] exp, input logic [1:0] resp = baud_pkg::RESP_OKAY);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (n == 64) stall("read");
        check("rresp", {30'h0, resp}, {30'h0, s_axi_rresp});
        if (resp == baud_pkg::RESP_OKAY) check("rdata", {24'h0, exp}, s_axi_rdata);
    endtask

    task automatic wait_tick(output int n);
        for (n = 1; n <= 5000; n++) begin
            @(posedge aclk);
            if (rate_tick === 1'b1) return;
        end
        stall("rate tick");
    endtask

    task automatic count_ticks(input int cycles, output int k);
        k = 0;
        repeat (cycles) begin
            @(posedge aclk);
            if (rate_tick === 1'b1) k++;
        end
    endtask

    task automatic send_word(input logic [8:0] w);
        rx_word <= w;
        rx_word_valid <= 1'b1;
        @(posedge aclk);
        rx_word_valid <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic test_registers;
        reg_read(baud_pkg::TXC_ADDR, 8'h02);
        reg_read(baud_pkg::RXC_ADDR, 8'h00);
        reg_read(baud_pkg::DIV_ADDR, 8'h00);
        shift_register_empty <= 1'b0;
        framing_error <= 1'b1;
        reg_write(baud_pkg::TXC_ADDR, 8'hFF);
        reg_read(baud_pkg::TXC_ADDR, 8'hF5);
        reg_write(baud_pkg::RXC_ADDR, 8'hFF);
        reg_read(baud_pkg::RXC_ADDR, 8'hFC);
        reg_write(baud_pkg::DIV_ADDR, 8'hA5);
        reg_read(baud_pkg::DIV_ADDR, 8'hA5);
        shift_register_empty <= 1'b1;
        framing_error <= 1'b0;
        reg_write(10'h3FC, 8'h11, baud_pkg::RESP_SLVERR);
        reg_read(10'h3FC, 8'h00, baud_pkg::RESP_SLVERR);
        reg_write(baud_pkg::RXC_ADDR, 8'h00);
    endtask

    task automatic test_periods;
        logic [7:0] txc [5] = '{8'h20, 8'h24, 8'h24, 8'hB0, 8'hB4};
        logic [7:0] div [5] = '{8'h02, 8'h00, 8'hFF, 8'h01, 8'h01};
        int         per [5] = '{192, 16, 4096, 8, 8};
        int         n;
        for (int i = 0; i < 5; i++) begin
            reg_write(baud_pkg::DIV_ADDR, div[i]);
            reg_write(baud_pkg::TXC_ADDR, txc[i]);
            wait_tick(n);
            wait_tick(n);
            check("period", per[i], n);
        end
    endtask

    task automatic test_idle;
        int k;
        reg_write(baud_pkg::TXC_ADDR, 8'h00);
        count_ticks(300, k);
        check("idle ticks", 0, k);
        reg_write(baud_pkg::TXC_ADDR, 8'h30);
        count_ticks(300, k);
        check("slave ticks", 0, k);
        reg_write(baud_pkg::TXC_ADDR, 8'h00);
        reg_write(baud_pkg::RXC_ADDR, 8'h10);
        count_ticks(350, k);
        check("rx ticks", 2, k);
        reg_write(baud_pkg::RXC_ADDR, 8'h00);
    endtask

    task automatic test_divisor_clear;
        int n;
        reg_write(baud_pkg::DIV_ADDR, 8'hFF);
        reg_write(baud_pkg::TXC_ADDR, 8'h24);
        wait_tick(n);
        repeat (100) @(posedge aclk);
        reg_write(baud_pkg::DIV_ADDR, 8'h00);
        wait_tick(n);
        check("first tick", 1, n <= 40);
        wait_tick(n);
        check("new period", 16, n);
        ce <= 1'b0;
        count_ticks(40, n);
        check("ce low ticks", 0, n);
        ce <= 1'b1;
    endtask

    task automatic test_majority;
        int n;
        line_glitch <= 1'b1;
        repeat (4) wait_tick(n);
        for (int i = 0; i < 16; i++) begin
            if (i == 8) begin
                line_level <= 1'b0;
                repeat (3) wait_tick(n);
            end
            wait_tick(n);
            @(posedge aclk);
            check("rx_level", {31'h0, i < 8}, {31'h0, rx_level});
        end
        line_level <= 1'b1;
        line_glitch <= 1'b0;
    endtask

    task automatic test_address;
        reg_write(baud_pkg::RXC_ADDR, 8'h98);
        send_word(9'h055);
        check("flag data", 0, {31'h0, receive_flag});
        send_word(9'h1AA);
        check("flag addr", 1, {31'h0, receive_flag});
        reg_read(baud_pkg::STATUS_ADDR, 8'h01);
        reg_read(baud_pkg::RXBUF_ADDR, 8'hAA);
        @(posedge aclk);
        check("flag read", 0, {31'h0, receive_flag});
        reg_write(baud_pkg::RXC_ADDR, 8'h90);
        send_word(9'h033);
        check("flag no detect", 1, {31'h0, receive_flag});
        reg_read(baud_pkg::RXBUF_ADDR, 8'h33);
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        test_registers();
        test_periods();
        test_idle();
        test_divisor_clear();
        test_majority();
        test_address();
        complete_run();
    end
endmodule
